/* File: hdl/sample_averager.sv */
// running mean over the last sixteen samples
`timescale 1ns/10ps
module sample_averager #(
	parameter int W = 12
) (
	input wire logic i_clk,
	input wire logic i_resetn,
	input wire logic [W-1:0] i_sample,
	input wire logic i_valid,
	output logic [W-1:0] o_mean
);
	import supply_ctrl_pkg::*;

	logic [W-1:0] hist [AVG_DEPTH];
	logic [AVG_SHIFT-1:0] ptr;
	logic [W+AVG_SHIFT-1:0] sum;
	wire [W+AVG_SHIFT-1:0] next_sum;

	// oldest sample leaves the sum as the new one enters
	assign next_sum = sum + {{AVG_SHIFT{1'b0}}, i_sample} - {{AVG_SHIFT{1'b0}}, hist[ptr]};

	always_ff @(posedge i_clk or negedge i_resetn) begin
		if (!i_resetn) begin
			for (int k = 0; k < AVG_DEPTH; k++) begin
				hist[k] <= '0;
			end
			ptr <= '0;
			sum <= '0;
			o_mean <= '0;
		end else if (i_valid) begin
			hist[ptr] <= i_sample;
			ptr <= ptr + 1'b1;
			sum <= next_sum;
			o_mean <= next_sum[W+AVG_SHIFT-1:AVG_SHIFT];
		end
	end

endmodule

/* File: hdl/supply_control_registers.sv */
// two-wire register bank of the supply controller: telemetry and set points
// What this block does
// - live status word carries ready, discharge, fault and comparator bits unlatched.
// - fault-cause word latches retry and shutdown causes until device reset.
// - averaged current word: top four bits zero, mean of sixteen samples.
// - averaged voltage word: top eight bits zero, mean of sixteen samples.
// - ready flag is one only while commands can be accepted.
// - write sub-address into 0x80, then read selected word back from it.
// - current limit compares against the averaged current, not raw samples.
// - voltage target accepts 3 V to 24 V at 10 mV per lsb.
// - voltage target resets to 5 V.
// - command addresses carry odd parity in bit 7; 0x18 becomes 0x98.
// - current limit accepts codes 25 to 128, each 1/128 of full scale.
`timescale 1ns/10ps
module supply_control_registers (
	input wire logic i_clk,
	input wire logic i_resetn,
	input wire logic i_scl,
	input wire logic i_sda,
	output logic o_sda,
	output logic o_sda_oe_n,
	input wire logic i_core_ready,
	input wire logic [15:0] i_live_flags,
	input wire logic [15:0] i_fault_events,
	input wire logic [15:0] i_irq_word,
	input wire logic [15:0] i_dac_word,
	input wire logic [supply_ctrl_pkg::CUR_W-1:0] i_current_sample,
	input wire logic i_current_valid,
	input wire logic [supply_ctrl_pkg::VOLT_W-1:0] i_voltage_sample,
	input wire logic i_voltage_valid,
	output logic o_system_ready,
	output logic [supply_ctrl_pkg::CV_W-1:0] o_voltage_target,
	output logic [supply_ctrl_pkg::CC_W-1:0] o_current_limit,
	output logic o_current_limit_hit
);
	import supply_ctrl_pkg::*;

	logic scl_s1, scl_s2, scl_d;
	logic sda_s1, sda_s2, sda_d;
	state_t state;
	logic [3:0] bitcnt;
	logic [7:0] shreg;
	logic [7:0] cmd;
	logic [7:0] wlow;
	logic [7:0] read_sel;
	logic [15:0] txword;
	logic [15:0] latched;
	logic byte_hi;
	logic rw;
	logic master_ack;
	logic cv_written;
	logic [CUR_W-1:0] avg_i;
	logic [VOLT_W-1:0] avg_v;

	// pins pass two flops before any logic looks at them
	always_ff @(posedge i_clk or negedge i_resetn) begin
		if (!i_resetn) begin
			scl_s1 <= 1'b1;
			scl_s2 <= 1'b1;
			scl_d <= 1'b1;
			sda_s1 <= 1'b1;
			sda_s2 <= 1'b1;
			sda_d <= 1'b1;
		end else begin
			scl_s1 <= i_scl;
			scl_s2 <= scl_s1;
			scl_d <= scl_s2;
			sda_s1 <= i_sda;
			sda_s2 <= sda_s1;
			sda_d <= sda_s2;
		end
	end

	wire scl_rise = scl_s2 & ~scl_d;
	wire scl_fall = ~scl_s2 & scl_d;
	wire bus_start = scl_s2 & scl_d & sda_d & ~sda_s2;
	wire bus_stop = scl_s2 & scl_d & ~sda_d & sda_s2;
	wire byte_in = scl_fall & (bitcnt == BITS_PER_BYTE);
	wire addr_match = (shreg[7:1] == DEV_ADDR);
	// odd number of ones marks a valid command byte
	wire cmd_parity_ok = ^shreg;

	// telemetry words
	// the ready bit comes only from the registered ready flag, never from the flag inputs
	wire [15:0] live_flag_mask = LIVE_MASK & ~(16'h0001 << READY_BIT);
	wire [15:0] live_word = (i_live_flags & live_flag_mask) | (16'(o_system_ready) << READY_BIT);
	wire [15:0] avg_i_word = {{(16-CUR_W){1'b0}}, avg_i};
	wire [15:0] avg_v_word = {{(16-VOLT_W){1'b0}}, avg_v};
	wire [15:0] sel_word = (read_sel == SEL_LIVE) ? live_word :
		(read_sel == SEL_LATCHED) ? latched :
		(read_sel == SEL_IRQ) ? i_irq_word :
		(read_sel == SEL_AVG_I) ? avg_i_word :
		(read_sel == SEL_AVG_V) ? avg_v_word :
		(read_sel == SEL_DAC) ? i_dac_word : 16'h0000;
	wire [7:0] next_tx_byte = byte_hi ? txword[7:0] : txword[15:8];

	// completed 16-bit command word and its payload fields
	wire word_done = (state == ST_WRITE) & byte_in & byte_hi;
	wire [15:0] word_in = {shreg, wlow};
	// bit 7 of each byte is its parity bit, so each byte carries seven payload bits
	wire [13:0] payload = {word_in[14:8], word_in[6:0]};
	wire [CV_W-1:0] cv_value = payload[CV_W-1:0];
	wire [CC_W-1:0] cc_value = payload[CC_W-1:0];
	wire cv_ok = (payload >= {2'b00, CV_MIN}) && (payload <= {2'b00, CV_MAX});
	wire cc_ok = (payload >= {6'h00, CC_MIN}) && (payload <= {6'h00, CC_MAX});
	wire cv_load = word_done && (cmd == CMD_CV) && cv_ok;
	wire cc_load = word_done && (cmd == CMD_CC) && cc_ok;
	wire sel_load = (state == ST_WRITE) && byte_in && (cmd == CMD_READ_SEL);

	// limit threshold on the current scale
	wire [CUR_W:0] cc_threshold = {o_current_limit, {CC_TO_CUR_SHIFT{1'b0}}};
	wire next_limit_hit = {1'b0, avg_i} >= cc_threshold;

	sample_averager #(.W(CUR_W)) current_avg (
		.i_clk(i_clk),
		.i_resetn(i_resetn),
		.i_sample(i_current_sample),
		.i_valid(i_current_valid),
		.o_mean(avg_i)
	);

	sample_averager #(.W(VOLT_W)) voltage_avg (
		.i_clk(i_clk),
		.i_resetn(i_resetn),
		.i_sample(i_voltage_sample),
		.i_valid(i_voltage_valid),
		.o_mean(avg_v)
	);

	always_ff @(posedge i_clk or negedge i_resetn) begin
		if (!i_resetn) begin
			state <= ST_IDLE;
			bitcnt <= '0;
			shreg <= '0;
			cmd <= '0;
			wlow <= '0;
			txword <= '0;
			byte_hi <= 1'b0;
			rw <= 1'b0;
			master_ack <= 1'b0;
			o_sda_oe_n <= 1'b1;
		end else if (bus_start) begin
			state <= ST_ADDR;
			bitcnt <= '0;
			o_sda_oe_n <= 1'b1;
		end else if (bus_stop) begin
			state <= ST_IDLE;
			o_sda_oe_n <= 1'b1;
		end else begin
			case (state)
				ST_ADDR, ST_CMD, ST_WRITE: begin
					if (scl_rise) begin
						shreg <= {shreg[6:0], sda_s2};
						bitcnt <= bitcnt + 1'b1;
					end
					if (byte_in) begin
						if (state == ST_ADDR) begin
							if (addr_match && o_system_ready) begin
								state <= ST_ADDR_ACK;
								rw <= shreg[0];
								o_sda_oe_n <= 1'b0;
							end else begin
								state <= ST_IDLE;
							end
						end else if (state == ST_CMD) begin
							if (cmd_parity_ok) begin
								state <= ST_CMD_ACK;
								cmd <= shreg;
								o_sda_oe_n <= 1'b0;
							end else begin
								state <= ST_IDLE;
							end
						end else begin
							// low byte arrives first, high byte completes the word
							state <= ST_WRITE_ACK;
							wlow <= shreg;
							byte_hi <= ~byte_hi;
							o_sda_oe_n <= 1'b0;
						end
					end
				end
				ST_ADDR_ACK: begin
					if (scl_fall) begin
						bitcnt <= '0;
						byte_hi <= 1'b0;
						if (rw) begin
							// a read returns the selected word, low byte first
							state <= ST_READ;
							txword <= sel_word;
							shreg <= sel_word[7:0];
							o_sda_oe_n <= sel_word[7];
						end else begin
							state <= ST_CMD;
							o_sda_oe_n <= 1'b1;
						end
					end
				end
				ST_CMD_ACK, ST_WRITE_ACK: begin
					if (scl_fall) begin
						state <= ST_WRITE;
						bitcnt <= '0;
						o_sda_oe_n <= 1'b1;
					end
				end
				ST_READ: begin
					if (scl_rise) begin
						bitcnt <= bitcnt + 1'b1;
					end
					if (byte_in) begin
						state <= ST_READ_ACK;
						o_sda_oe_n <= 1'b1;
					end else if (scl_fall) begin
						shreg <= {shreg[6:0], 1'b0};
						o_sda_oe_n <= shreg[6];
					end
				end
				ST_READ_ACK: begin
					if (scl_rise) begin
						master_ack <= ~sda_s2;
					end
					if (scl_fall) begin
						bitcnt <= '0;
						if (master_ack) begin
							state <= ST_READ;
							byte_hi <= ~byte_hi;
							shreg <= next_tx_byte;
							o_sda_oe_n <= next_tx_byte[7];
						end else begin
							state <= ST_IDLE;
							o_sda_oe_n <= 1'b1;
						end
					end
				end
				default: begin
					state <= ST_IDLE;
					o_sda_oe_n <= 1'b1;
				end
			endcase
		end
	end

	always_ff @(posedge i_clk or negedge i_resetn) begin
		if (!i_resetn) begin
			o_sda <= 1'b0;
			o_system_ready <= 1'b0;
			latched <= '0;
			read_sel <= SEL_RESET;
			cv_written <= 1'b0;
			o_current_limit_hit <= 1'b0;
		end else begin
			o_sda <= 1'b0;
			// ready follows the core's ability to take commands
			o_system_ready <= i_core_ready;
			// causes stay set until the device resets
			latched <= latched | (i_fault_events & LATCH_MASK);
			// sub-address written to 0x80 selects the read-back word
			if (sel_load) begin
				read_sel <= shreg;
			end
			if (cv_load) begin
				cv_written <= 1'b1;
			end
			// limit judged on the averaged current
			o_current_limit_hit <= next_limit_hit;
		end
	end

	always_ff @(posedge i_clk or negedge i_resetn) begin
		if (!i_resetn) begin
			o_voltage_target <= CV_RESET;
			o_current_limit <= CC_RESET;
		end else begin
			// out-of-range voltage codes leave the target unchanged
			if (cv_load) begin
				o_voltage_target <= cv_value;
			end
			// current codes outside 25..128 are dropped
			if (cc_load) begin
				o_current_limit <= cc_value;
			end
		end
	end

	chk_live_layout: assert property (@(posedge i_clk) disable iff (!i_resetn)
		(live_word[READY_BIT] == o_system_ready) && ((live_word & ~LIVE_MASK) == 16'h0000))
		else $error("live status word layout wrong");

	chk_latch_sticky: assert property (@(posedge i_clk) disable iff (!i_resetn)
		((latched & $past(latched)) == $past(latched))
		&& (($past(i_fault_events) & LATCH_MASK & ~latched) == 16'h0000))
		else $error("latched cause lost or missed");

	chk_avg_i_zero: assert property (@(posedge i_clk) disable iff (!i_resetn)
		avg_i_word[15:12] == 4'h0)
		else $error("averaged current top bits not zero");

	chk_avg_v_zero: assert property (@(posedge i_clk) disable iff (!i_resetn)
		avg_v_word[15:8] == 8'h00)
		else $error("averaged voltage top bits not zero");

	chk_nack_unready: assert property (@(posedge i_clk) disable iff (!i_resetn)
		(state == ST_ADDR && byte_in && !o_system_ready && !bus_start && !bus_stop)
		|=> (state == ST_IDLE) && o_sda_oe_n)
		else $error("address acknowledged while not ready");

	chk_select_capture: assert property (@(posedge i_clk) disable iff (!i_resetn)
		(sel_load && !bus_start && !bus_stop) |=> (read_sel == $past(shreg)))
		else $error("read select not captured");

	chk_limit_avg: assert property (@(posedge i_clk) disable iff (!i_resetn)
		$past(i_resetn) |->
		(o_current_limit_hit == ({1'b0, $past(avg_i)} >= (13'($past(o_current_limit)) << 5))))
		else $error("limit flag not tied to averaged current");

	chk_cv_range: assert property (@(posedge i_clk) disable iff (!i_resetn)
		(o_voltage_target >= CV_MIN) && (o_voltage_target <= CV_MAX))
		else $error("voltage target out of range");

	chk_cv_default: assert property (@(posedge i_clk) disable iff (!i_resetn)
		!cv_written |-> (o_voltage_target == CV_RESET))
		else $error("voltage target left default without a write");

	chk_parity_refuse: assert property (@(posedge i_clk) disable iff (!i_resetn)
		(state == ST_CMD && byte_in && !cmd_parity_ok && !bus_start && !bus_stop)
		|=> (state == ST_IDLE) && o_sda_oe_n)
		else $error("even parity command accepted");

	chk_cc_range: assert property (@(posedge i_clk) disable iff (!i_resetn)
		(o_current_limit >= CC_MIN) && (o_current_limit <= CC_MAX))
		else $error("current limit out of range");

	cov_read_word: cover property (@(posedge i_clk) disable iff (!i_resetn)
		(state == ST_READ_ACK) && master_ack && byte_hi);

	cov_cv_write: cover property (@(posedge i_clk) disable iff (!i_resetn) cv_load);

	cov_cc_write: cover property (@(posedge i_clk) disable iff (!i_resetn) cc_load);

	cov_select: cover property (@(posedge i_clk) disable iff (!i_resetn)
		sel_load && (shreg == SEL_LIVE));

endmodule

/* File: include/supply_ctrl_pkg.sv */
// shared constants and types for the supply control register bank
package supply_ctrl_pkg;

	// bus target address, seven bits (write byte 0x30)
	localparam logic [6:0] DEV_ADDR = 7'h18;

	// command bytes as sent on the bus, odd parity in bit 7
	localparam logic [7:0] CMD_CV = 8'h10;
	localparam logic [7:0] CMD_CC = 8'h98;
	localparam logic [7:0] CMD_READ_SEL = 8'h80;

	// telemetry sub-addresses
	localparam logic [7:0] SEL_LIVE = 8'h14;
	localparam logic [7:0] SEL_LATCHED = 8'h16;
	localparam logic [7:0] SEL_IRQ = 8'h18;
	localparam logic [7:0] SEL_AVG_I = 8'h1a;
	localparam logic [7:0] SEL_AVG_V = 8'h1c;
	localparam logic [7:0] SEL_DAC = 8'h5c;
	localparam logic [7:0] SEL_RESET = SEL_LIVE;

	// live and latched word layouts
	localparam int READY_BIT = 14;
	localparam logic [15:0] LIVE_MASK = 16'hf23b;
	localparam logic [15:0] LATCH_MASK = 16'h96f7;

	// measurement widths and averaging depth
	localparam int CUR_W = 12;
	localparam int VOLT_W = 8;
	localparam int AVG_DEPTH = 16;
	localparam int AVG_SHIFT = 4;

	// voltage target, 10 mV per lsb: 3 V .. 24 V, reset 5 V
	localparam int CV_W = 12;
	localparam logic [CV_W-1:0] CV_MIN = 12'h12c;
	localparam logic [CV_W-1:0] CV_MAX = 12'h960;
	localparam logic [CV_W-1:0] CV_RESET = 12'h1f4;

	// current limit code, 1/128 of full scale per step
	localparam int CC_W = 8;
	localparam logic [CC_W-1:0] CC_MIN = 8'h19;
	localparam logic [CC_W-1:0] CC_MAX = 8'h80;
	localparam logic [CC_W-1:0] CC_RESET = 8'h80;
	localparam int CC_TO_CUR_SHIFT = 5;

	localparam logic [3:0] BITS_PER_BYTE = 4'h8;

	typedef enum logic [3:0] {
		ST_IDLE,
		ST_ADDR,
		ST_ADDR_ACK,
		ST_CMD,
		ST_CMD_ACK,
		ST_WRITE,
		ST_WRITE_ACK,
		ST_READ,
		ST_READ_ACK
	} state_t;

endpackage

/* File: tb/tb.sv */
// self-checking bench for the supply control register bank
`timescale 1ns/10ps
module tb;
	import supply_ctrl_pkg::*;
	logic clk = 1'b0;
	logic resetn = 1'b0;
	logic core_ready = 1'b0;
	logic scl, sda_low, sda, sda_out, sda_oe_n, ready, hit;
	logic [15:0] live = 16'hffff;
	logic [15:0] fault = 16'h0000;
	logic [15:0] w;
	logic [11:0] cur = 12'h000;
	logic [7:0] volt = 8'h00;
	logic cur_v = 1'b0;
	logic volt_v = 1'b0;
	logic [11:0] vt;
	logic [7:0] cl;
	logic [3:0] acks;
	int fail_count = 0;
	int checks_done = 0;
	int cycles = 0;
	logic [15:0] wtab[10] = '{16'h8620, 16'h92e0, 16'h9261, 16'h02ab, 16'h022c,
		16'h8040, 16'h8098, 16'h8019, 16'h0101, 16'h0180};
	logic [11:0] etab[10] = '{12'd800, 12'd2400, 12'd2400, 12'd2400, 12'd300,
		12'h040, 12'h040, 12'd25, 12'd25, 12'd128};
	logic [7:0] stab[6] = '{SEL_LATCHED, SEL_IRQ, SEL_DAC, SEL_AVG_I, SEL_AVG_V, 8'h20};
	logic [15:0] xtab[6] = '{16'h96f7, 16'h1234, 16'h5c3a, 16'h04bf, 16'h007f, 16'h0000};

	assign sda = ~(sda_low | (~sda_oe_n & ~sda_out));
	always #50 clk = ~clk;

	twowire_master mst (.i_clk(clk), .i_sda(sda), .o_scl(scl), .o_sda_low(sda_low));

	supply_control_registers i_dut (
		.i_clk(clk), .i_resetn(resetn), .i_scl(scl), .i_sda(sda),
		.o_sda(sda_out), .o_sda_oe_n(sda_oe_n), .i_core_ready(core_ready),
		.i_live_flags(live), .i_fault_events(fault), .i_irq_word(16'h1234),
		.i_dac_word(16'h5c3a), .i_current_sample(cur), .i_current_valid(cur_v),
		.i_voltage_sample(volt), .i_voltage_valid(volt_v), .o_system_ready(ready),
		.o_voltage_target(vt), .o_current_limit(cl), .o_current_limit_hit(hit)
	);

	task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
		checks_done++;
		if (got !== exp) begin
			fail_count++;
			$display("wrong value %s expected %h seen %h", what, exp, got);
		end
	endtask

	task automatic wr(input logic [7:0] cmd, input logic [15:0] d);
		mst.start();
		mst.send({DEV_ADDR, 1'b0}, acks[3]);
		mst.send(cmd, acks[2]);
		mst.send(d[7:0], acks[1]);
		mst.send(d[15:8], acks[0]);
		mst.stop();
		repeat (4) @(negedge clk);
	endtask

	task automatic rd(input logic [7:0] sel, output logic [15:0] d);
		logic a;
		mst.start();
		mst.send({DEV_ADDR, 1'b0}, a);
		mst.send(CMD_READ_SEL, a);
		mst.send(sel, a);
		mst.send(sel, a);
		mst.stop();
		mst.start();
		mst.send({DEV_ADDR, 1'b1}, a);
		mst.recv(1'b1, d[7:0]);
		mst.recv(1'b0, d[15:8]);
		mst.stop();
	endtask

	task automatic feed(input logic [11:0] c, input logic [7:0] v);
		@(negedge clk);
		cur = c;
		volt = v;
		cur_v = 1'b1;
		volt_v = 1'b1;
		@(negedge clk);
		cur_v = 1'b0;
		volt_v = 1'b0;
	endtask

	task automatic tally_and_finish();
		$display("checks %0d mismatches %0d", checks_done, fail_count);
		if (fail_count == 0 && checks_done > 0) begin
			$display("Run complete: PASS");
		end else begin
			$display("Run complete: FAIL");
		end
		$finish;
	endtask

	always @(posedge clk) begin
		cycles <= cycles + 1;
		if (cycles == 60000) begin
			fail_count++;
			tally_and_finish();
		end
	end

	initial begin
		repeat (2) @(negedge clk);
		resetn = 1'b1;
		repeat (2) @(negedge clk);
		chk("target at reset", 16'd500, {4'h0, vt});
		chk("limit at reset", 16'd128, {8'h0, cl});
		chk("ready while core busy", 16'h0000, {15'h0, ready});
		wr(CMD_CV, 16'h8620);
		chk("acks while not ready", 16'h0000, {12'h0, acks});
		chk("target kept", 16'd500, {4'h0, vt});
		$display("test not_ready done");
		core_ready = 1'b1;
		repeat (4) @(negedge clk);
		rd(SEL_LIVE, w);
		chk("live word", 16'hf23b, w);
		live = 16'h4dc4;
		rd(SEL_LIVE, w);
		chk("live word inverse", 16'h4000, w);
		$display("test live_status done");
		for (int i = 0; i < 10; i++) begin
			wr((i < 5) ? CMD_CV : CMD_CC, wtab[i]);
			chk("set point acks", 16'h000f, {12'h0, acks});
			chk("set point", {4'h0, etab[i]}, (i < 5) ? {4'h0, vt} : {8'h0, cl});
		end
		wr(8'h18, 16'h0040);
		chk("even parity acks", 16'h0008, {12'h0, acks});
		chk("limit kept", 16'd128, {8'h0, cl});
		wr(CMD_CC, 16'h8019);
		$display("test set_points done");
		@(negedge clk);
		fault = 16'hffff;
		@(negedge clk);
		fault = 16'h0000;
		feed(12'hfff, 8'hff);
		repeat (4) @(negedge clk);
		chk("limit on raw sample", 16'h0000, {15'h0, hit});
		for (int i = 0; i < 15; i++) begin
			feed(12'h400, i[0] ? 8'hff : 8'h00);
		end
		repeat (4) @(negedge clk);
		chk("limit on mean", 16'h0001, {15'h0, hit});
		for (int i = 0; i < 6; i++) begin
			rd(stab[i], w);
			chk("telemetry word", xtab[i], w);
		end
		feed(12'h400, 8'h00);
		rd(SEL_AVG_I, w);
		chk("mean after window slides", 16'h0400, w);
		$display("test telemetry done");
		@(negedge clk);
		resetn = 1'b0;
		repeat (2) @(negedge clk);
		chk("ready in reset", 16'h0000, {15'h0, ready});
		resetn = 1'b1;
		repeat (4) @(negedge clk);
		chk("target after reset", 16'd500, {4'h0, vt});
		rd(SEL_LIVE, w);
		chk("ready after reset", 16'h4000, w & 16'h4000);
		rd(SEL_LATCHED, w);
		chk("causes cleared", 16'h0000, w);
		$display("test second_reset done");
		tally_and_finish();
	end
endmodule

/* File: tb/twowire_master.sv */
// two-wire bus controller model driving clock and data from the far side
`timescale 1ns/10ps
module twowire_master (
	input wire logic i_clk,
	input wire logic i_sda,
	output logic o_scl,
	output logic o_sda_low
);
	initial begin
		o_scl = 1'b1;
		o_sda_low = 1'b0;
	end

	task automatic half();
		repeat (10) @(negedge i_clk);
	endtask

	task automatic start();
		o_sda_low = 1'b1;
		half();
		o_scl = 1'b0;
	endtask

	task automatic stop();
		repeat (4) @(negedge i_clk);
		o_sda_low = 1'b1;
		repeat (6) @(negedge i_clk);
		o_scl = 1'b1;
		half();
		o_sda_low = 1'b0;
		half();
	endtask

	// data moves well after the clock fall, sampled at the end of the high phase
	task automatic bit_io(input logic b, output logic r);
		repeat (4) @(negedge i_clk);
		o_sda_low = ~b;
		repeat (6) @(negedge i_clk);
		o_scl = 1'b1;
		half();
		r = i_sda;
		o_scl = 1'b0;
	endtask

	task automatic send(input logic [7:0] d, output logic ack);
		logic r;
		for (int i = 7; i >= 0; i--) begin
			bit_io(d[i], r);
		end
		bit_io(1'b1, r);
		ack = ~r;
	endtask

	task automatic recv(input logic more, output logic [7:0] d);
		logic r;
		for (int i = 7; i >= 0; i--) begin
			bit_io(1'b1, r);
			d[i] = r;
		end
		bit_io(~more, r);
	endtask
endmodule
